// ---- ssa_alu.sv ----
// Top of the packed integer multimedia datapath: issue checks, element
// arithmetic, identification reply, and the registered result port.
// Assumes the issue port is driven by core logic on clk_sys, no pins.
//
// Notes on behaviour
// - Every operation has a 64-bit narrow and a 128-bit wide form.
// - Word horizontal add sums adjacent signed words, wrapping to 16 bits.
// - Saturating word horizontal add clamps each pair sum to signed 16 bits.
// - Dword horizontal add sums adjacent signed dwords into 32-bit results.
// - Word horizontal subtract gives lower minus upper word, wrapping.
// - Saturating word horizontal subtract clamps lower minus upper to 16 bits.
// - Dword horizontal subtract gives lower minus upper dword.
// - Packed absolute value writes each element magnitude, unsigned, same width.
// - Unsigned dst byte times signed src byte, adjacent sums saturated to 16.
// - High multiply forms signed 32-bit products, keeps the top 18 bits.
// - Add one to the 18-bit value, output 16 bits under its top bit.
// - Shuffle picks dst byte by low three or four control bits.
// - Shuffle writes zero where the control byte has bit 7 set.
// - Shuffle leaves the control mask operand untouched.
// - Packed sign negates dst elements whose source element is negative.
// - Align right shifts dst:src composite by immediate bytes, keeps one width.
// - Feature leaf 01H reports the group as ECX bit 9.
// - Group absent: invalid opcode fault, whatever task switched holds.
// - Task switched set: device not available fault on the group.
// - Emulation flag set: invalid opcode instead of device not available.
`timescale 1ns/1ps
module ssa_alu (
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  input  wire logic                         groupPresent,
  input  wire logic                         task_switched_flag,
  input  wire logic                         emulation_control_flag,
  input  wire logic                         issueValid,
  input  wire ssa_pkg::ssa_op_e             issueOp,
  input  wire logic                         issueWide,
  input  wire logic [7:0]                   issueImm,
  input  wire logic [ssa_pkg::VEC_WIDE-1:0] issueDst,
  input  wire logic [ssa_pkg::VEC_WIDE-1:0] issueSrc,
  input  wire logic                         idQuery,
  input  wire logic [31:0]                  idLeaf,
  output logic                              resultValid,
  output logic [ssa_pkg::VEC_WIDE-1:0]      result,
  output logic                              faultInvalidOp,
  output logic                              faultDevNa,
  output logic                              idValid,
  output logic [31:0]                       idEcx
);
  import ssa_pkg::*;

  ssa_state_s          st;
  ssa_state_s          next_st;
  logic [VEC_WIDE-1:0] horizResult;
  logic [VEC_WIDE-1:0] permResult;
  logic [VEC_WIDE-1:0] elemResult;
  logic [VEC_WIDE-1:0] narrowMask;

  ssa_opnd_if opnd ();

  // Sub-units see the issue operands directly
  assign opnd.op   = issueOp;
  assign opnd.wide = issueWide;
  assign opnd.imm  = issueImm;
  assign opnd.dst  = issueDst;
  assign opnd.src  = issueSrc;

  ssa_horiz u_horiz (
    .opnd   (opnd.unit),
    .result (horizResult)
  );

  ssa_permute u_permute (
    .opnd   (opnd.unit),
    .result (permResult)
  );

  // Narrow forms only produce the low 64 bits
  assign narrowMask = issueWide ? {VEC_WIDE{1'b1}}
                                : {{VEC_NARROW{1'b0}}, {VEC_NARROW{1'b1}}};

  // Per-element arithmetic: absolute value, sign, multiply forms
  always_comb begin
    logic [7:0]  d8;
    logic [7:0]  s8;
    logic [15:0] d16;
    logic [15:0] s16;
    logic [31:0] d32;
    logic [31:0] s32;
    logic [15:0] pLo;
    logic [15:0] pHi;
    logic [31:0] prod;
    logic [17:0] trunc18;
    d8 = '0;
    s8 = '0;
    d16 = '0;
    s16 = '0;
    d32 = '0;
    s32 = '0;
    pLo = '0;
    pHi = '0;
    prod = '0;
    trunc18 = '0;
    elemResult = '0;
    unique case (issueOp)
      OP_ABS_BYTE, OP_NEGATE_BYTE: begin
        for (int i = 0; i < BYTES_WIDE; i++) begin
          d8 = issueDst[W_BYTE*i +: W_BYTE];
          s8 = issueSrc[W_BYTE*i +: W_BYTE];
          if (issueOp == OP_ABS_BYTE) begin
            elemResult[W_BYTE*i +: W_BYTE] = s8[7] ? 8'h00 - s8 : s8;
          end else begin
            elemResult[W_BYTE*i +: W_BYTE] = s8[7] ? 8'h00 - d8 : d8;
          end
        end
      end
      OP_ABS_WORD, OP_NEGATE_WORD: begin
        for (int i = 0; i < WORDS_WIDE; i++) begin
          d16 = issueDst[W_WORD*i +: W_WORD];
          s16 = issueSrc[W_WORD*i +: W_WORD];
          if (issueOp == OP_ABS_WORD) begin
            elemResult[W_WORD*i +: W_WORD] = s16[15] ? 16'h0000 - s16
                                                     : s16;
          end else begin
            elemResult[W_WORD*i +: W_WORD] = s16[15] ? 16'h0000 - d16
                                                     : d16;
          end
        end
      end
      OP_ABS_DWORD, OP_NEGATE_DWORD: begin
        for (int i = 0; i < DWORDS_WIDE; i++) begin
          d32 = issueDst[W_DWORD*i +: W_DWORD];
          s32 = issueSrc[W_DWORD*i +: W_DWORD];
          if (issueOp == OP_ABS_DWORD) begin
            elemResult[W_DWORD*i +: W_DWORD] = s32[31] ? 32'h0 - s32
                                                       : s32;
          end else begin
            elemResult[W_DWORD*i +: W_DWORD] = s32[31] ? 32'h0 - d32
                                                       : d32;
          end
        end
      end
      OP_BYTE_MUL_PAIR_ADD_SAT: begin
        // Unsigned times signed byte always fits a signed 16-bit product
        for (int i = 0; i < WORDS_WIDE; i++) begin
          pLo = 16'($signed({1'b0, issueDst[W_WORD*i +: W_BYTE]})
                * $signed(issueSrc[W_WORD*i +: W_BYTE]));
          pHi = 16'($signed({1'b0, issueDst[W_WORD*i+W_BYTE +: W_BYTE]})
                * $signed(issueSrc[W_WORD*i+W_BYTE +: W_BYTE]));
          elemResult[W_WORD*i +: W_WORD] =
            ssa_sat16({pLo[15], pLo} + {pHi[15], pHi});
        end
      end
      OP_MUL_HIGH_ROUND_SCALE: begin
        for (int i = 0; i < WORDS_WIDE; i++) begin
          prod = $signed(issueDst[W_WORD*i +: W_WORD])
                 * $signed(issueSrc[W_WORD*i +: W_WORD]);
          trunc18 = prod[MULH_LSB +: MULH_BITS] + 18'h00001;
          elemResult[W_WORD*i +: W_WORD] = trunc18[MULH_BITS-2:1];
        end
      end
      default: begin
        elemResult = '0;
      end
    endcase
  end

  // Fault priority: absent group, then emulation, then task switched
  always_comb begin
    logic [VEC_WIDE-1:0] raw;
    raw     = '0;
    next_st = st;
    next_st.resultValid    = 1'b0;
    next_st.faultInvalidOp = 1'b0;
    next_st.faultDevNa     = 1'b0;
    next_st.idValid        = 1'b0;
    unique case (issueOp)
      OP_HADD_WORD_WRAP, OP_HADD_WORD_SATURATE, OP_HADD_DWORD_WRAP,
      OP_HSUB_WORD_WRAP, OP_HSUB_WORD_SATURATE, OP_HSUB_DWORD_WRAP: begin
        raw = horizResult;
      end
      OP_BYTE_SHUFFLE, OP_BYTE_ALIGN_RIGHT: begin
        raw = permResult;
      end
      default: begin
        raw = elemResult;
      end
    endcase
    if (issueValid) begin
      if (!groupPresent) begin
        next_st.faultInvalidOp = 1'b1;
      end else if (emulation_control_flag) begin
        next_st.faultInvalidOp = 1'b1;
      end else if (task_switched_flag) begin
        next_st.faultDevNa = 1'b1;
      end else begin
        next_st.resultValid = 1'b1;
        next_st.result      = raw & narrowMask;
      end
    end
    // Identification reply; only the feature leaf carries the flag
    if (idQuery) begin
      next_st.idValid = 1'b1;
      next_st.idEcx   = ECX_RESET;
      if (idLeaf == LEAF_FEATURES) begin
        next_st.idEcx[CAP_BIT] = groupPresent;
      end
    end
  end

  // Single state register; result is held between issues
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '{resultValid: 1'b0, result: '0, faultInvalidOp: 1'b0,
              faultDevNa: 1'b0, idValid: 1'b0, idEcx: ECX_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign resultValid    = st.resultValid;
  assign result         = st.result;
  assign faultInvalidOp = st.faultInvalidOp;
  assign faultDevNa     = st.faultDevNa;
  assign idValid        = st.idValid;
  assign idEcx          = st.idEcx;

  // Checks on outputs against their causes one cycle earlier
  a_absent_invalid_op:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && !groupPresent |=> faultInvalidOp && !faultDevNa
                                    && !resultValid)
  else $error("absent group did not fault as invalid opcode");

  a_emulation_wins:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && groupPresent && emulation_control_flag
      |=> faultInvalidOp && !faultDevNa)
  else $error("emulation flag did not give invalid opcode");

  a_task_switched_dna:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && groupPresent && !emulation_control_flag
      && task_switched_flag |=> faultDevNa && !resultValid)
  else $error("task switched did not give device not available");

  a_narrow_upper_zero:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && !issueWide ##1 resultValid
      |-> result[VEC_WIDE-1:VEC_NARROW] == '0)
  else $error("narrow form wrote upper half");

  a_id_cap_bit:
  assert property (@(posedge clk_sys) disable iff (reset)
    idQuery && idLeaf == LEAF_FEATURES
      |=> idValid && idEcx[CAP_BIT] == $past(groupPresent))
  else $error("capability bit does not match group presence");

  a_shuffle_zero_byte:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && issueOp == OP_BYTE_SHUFFLE && issueSrc[SHUF_ZERO_BIT]
      |=> !resultValid || result[W_BYTE-1:0] == 8'h00)
  else $error("shuffle byte with zero bit set was not cleared");

  a_shuffle_pick_byte:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && issueOp == OP_BYTE_SHUFFLE && issueWide
      && !issueSrc[SHUF_ZERO_BIT]
      |=> !resultValid || result[W_BYTE-1:0] ==
        $past(issueDst[W_BYTE*issueSrc[SHUF_IDX_WIDE-1:0] +: W_BYTE]))
  else $error("shuffle picked the wrong byte");

  a_hadd_dst_low:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && issueOp == OP_HADD_DWORD_WRAP
      |=> !resultValid || result[W_DWORD-1:0] ==
        $past(issueDst[W_DWORD-1:0] + issueDst[2*W_DWORD-1:W_DWORD]))
  else $error("dword horizontal add low lane wrong");

  a_abs_byte_sign:
  assert property (@(posedge clk_sys) disable iff (reset)
    issueValid && issueOp == OP_ABS_BYTE && issueSrc[W_BYTE-1]
      && issueSrc[W_BYTE-2:0] != '0
      |=> !resultValid || result[W_BYTE-1:0] ==
        8'($past(8'h00 - issueSrc[W_BYTE-1:0])))
  else $error("byte absolute value wrong");

  a_no_spurious_out:
  assert property (@(posedge clk_sys) disable iff (reset)
    !issueValid |=> !resultValid && !faultDevNa && !faultInvalidOp)
  else $error("output pulse without an issue");

endmodule

// ---- ssa_pkg.sv ----
// Package for the packed integer multimedia datapath: widths, opcodes,
// identification constants, state layout and shared saturation helper.
// Assumes the core clock and synchronous reset of the issuing pipeline.
package ssa_pkg;

  // Operand and element geometry
  localparam int VEC_WIDE    = 128;
  localparam int VEC_NARROW  = 64;
  localparam int W_BYTE      = 8;
  localparam int W_WORD      = 16;
  localparam int W_DWORD     = 32;
  localparam int BYTES_WIDE  = VEC_WIDE / W_BYTE;
  localparam int WORDS_WIDE  = VEC_WIDE / W_WORD;
  localparam int DWORDS_WIDE = VEC_WIDE / W_DWORD;

  // Rounded high multiply: 18 kept bits start at product bit 14
  localparam int MULH_LSB    = 14;
  localparam int MULH_BITS   = 18;

  // Shuffle control byte layout
  localparam int SHUF_ZERO_BIT   = 7;
  localparam int SHUF_IDX_NARROW = 3;
  localparam int SHUF_IDX_WIDE   = 4;

  // Identification query: feature leaf and flag position in its ECX word
  localparam logic [31:0] LEAF_FEATURES = 32'h0000_0001;
  localparam int          CAP_BIT       = 9;
  localparam logic [31:0] ECX_RESET     = 32'h0000_0000;

  typedef enum logic [4:0] {
    OP_HADD_WORD_WRAP, OP_HADD_WORD_SATURATE, OP_HADD_DWORD_WRAP,
    OP_HSUB_WORD_WRAP, OP_HSUB_WORD_SATURATE, OP_HSUB_DWORD_WRAP,
    OP_ABS_BYTE, OP_ABS_WORD, OP_ABS_DWORD,
    OP_BYTE_MUL_PAIR_ADD_SAT, OP_MUL_HIGH_ROUND_SCALE,
    OP_BYTE_SHUFFLE,
    OP_NEGATE_BYTE, OP_NEGATE_WORD, OP_NEGATE_DWORD,
    OP_BYTE_ALIGN_RIGHT
  } ssa_op_e;

  typedef struct packed {
    logic                resultValid;
    logic [VEC_WIDE-1:0] result;
    logic                faultInvalidOp;
    logic                faultDevNa;
    logic                idValid;
    logic [31:0]         idEcx;
  } ssa_state_s;

  // Clamp a 17-bit signed sum into the signed 16-bit range
  function automatic logic [15:0] ssa_sat16(input logic [16:0] v);
    if (v[16] != v[15]) begin
      return v[16] ? 16'h8000 : 16'h7FFF;
    end
    return v[15:0];
  endfunction

endpackage

// ---- ssa_opnd_if.sv ----
// Operand bundle passed from the datapath top to its sub-units.
// Assumes the top drives it combinationally from the issue port.
`timescale 1ns/1ps
interface ssa_opnd_if;
  import ssa_pkg::*;
  ssa_op_e             op;
  logic                wide;
  logic [7:0]          imm;
  logic [VEC_WIDE-1:0] dst;
  logic [VEC_WIDE-1:0] src;
  modport core (output op, wide, imm, dst, src);
  modport unit (input op, wide, imm, dst, src);
endinterface

// ---- ssa_horiz.sv ----
// Horizontal add and subtract unit, word and dword, wrapping or saturating.
// Assumes operands are held stable by the caller for one combinational pass.
`timescale 1ns/1ps
module ssa_horiz (
  ssa_opnd_if.unit                  opnd,
  output logic [ssa_pkg::VEC_WIDE-1:0] result
);
  import ssa_pkg::*;

  // Destination pairs fill the low half, source pairs the high half
  always_comb begin
    logic [VEC_WIDE-1:0] v;
    logic [16:0]         s17;
    logic [31:0]         s32;
    logic                isSub;
    int                  half;
    int                  k;
    v     = '0;
    half  = 0;
    k     = 0;
    result = '0;
    s17   = '0;
    s32   = '0;
    isSub = opnd.op inside {OP_HSUB_WORD_WRAP, OP_HSUB_WORD_SATURATE,
                            OP_HSUB_DWORD_WRAP};
    if (opnd.op inside {OP_HADD_DWORD_WRAP, OP_HSUB_DWORD_WRAP}) begin
      half = opnd.wide ? DWORDS_WIDE / 2 : DWORDS_WIDE / 4;
      for (int i = 0; i < DWORDS_WIDE; i++) begin
        k = (i < half) ? 2 * i : 2 * (i - half);
        v = (i < half) ? opnd.dst : opnd.src;
        s32 = isSub ? v[W_DWORD*k +: W_DWORD] - v[W_DWORD*(k+1) +: W_DWORD]
                    : v[W_DWORD*k +: W_DWORD] + v[W_DWORD*(k+1) +: W_DWORD];
        if (i < 2 * half) begin
          result[W_DWORD*i +: W_DWORD] = s32;
        end
      end
    end else begin
      half = opnd.wide ? WORDS_WIDE / 2 : WORDS_WIDE / 4;
      for (int i = 0; i < WORDS_WIDE; i++) begin
        k = (i < half) ? 2 * i : 2 * (i - half);
        v = (i < half) ? opnd.dst : opnd.src;
        // Lower element minus upper element for subtract forms
        s17 = isSub
          ? {v[W_WORD*k+15], v[W_WORD*k +: W_WORD]}
            - {v[W_WORD*(k+1)+15], v[W_WORD*(k+1) +: W_WORD]}
          : {v[W_WORD*k+15], v[W_WORD*k +: W_WORD]}
            + {v[W_WORD*(k+1)+15], v[W_WORD*(k+1) +: W_WORD]};
        if (i < 2 * half) begin
          if (opnd.op inside {OP_HADD_WORD_SATURATE, OP_HSUB_WORD_SATURATE})
          begin
            result[W_WORD*i +: W_WORD] = ssa_sat16(s17);
          end else begin
            result[W_WORD*i +: W_WORD] = s17[15:0];
          end
        end
      end
    end
  end

endmodule

// ---- ssa_permute.sv ----
// Byte shuffle and byte align-right unit.
// Assumes narrow operands sit in the low 64 bits; upper result bits are zero.
`timescale 1ns/1ps
module ssa_permute (
  ssa_opnd_if.unit                     opnd,
  output logic [ssa_pkg::VEC_WIDE-1:0] result
);
  import ssa_pkg::*;

  // Shuffle reads only; the control mask operand is never written back
  always_comb begin
    logic [2*VEC_WIDE-1:0] cat;
    logic [10:0]           shamt;
    logic [7:0]            ctl;
    logic [3:0]            idx;
    int                    nBytes;
    result = '0;
    cat    = '0;
    ctl    = '0;
    idx    = '0;
    shamt  = {opnd.imm, 3'h0};
    nBytes = opnd.wide ? BYTES_WIDE : BYTES_WIDE / 2;
    if (opnd.op == OP_BYTE_SHUFFLE) begin
      for (int i = 0; i < BYTES_WIDE; i++) begin
        ctl = opnd.src[W_BYTE*i +: W_BYTE];
        // Narrow form uses three index bits, wide form four
        idx = opnd.wide ? ctl[SHUF_IDX_WIDE-1:0]
                        : {1'b0, ctl[SHUF_IDX_NARROW-1:0]};
        if (i < nBytes && !ctl[SHUF_ZERO_BIT]) begin
          result[W_BYTE*i +: W_BYTE] = opnd.dst[W_BYTE*idx +: W_BYTE];
        end
      end
    end else begin
      // Destination above source; offsets past the composite give zero
      if (opnd.wide) begin
        cat = {opnd.dst, opnd.src} >> shamt;
        result = cat[VEC_WIDE-1:0];
      end else begin
        cat = {{VEC_WIDE{1'b0}}, opnd.dst[VEC_NARROW-1:0],
               opnd.src[VEC_NARROW-1:0]} >> shamt;
        result = {{VEC_NARROW{1'b0}}, cat[VEC_NARROW-1:0]};
      end
    end
  end

endmodule

// ---- ssa_issue_model.sv ----
// Issue-side model: replays queued instructions onto the issue port.
// Assumes clk_sys from the bench; drives 1 ns after each rising edge.
`timescale 1ns/1ps
module ssa_issue_model (
  input  wire logic                   clk_sys,
  output logic                        issueValid,
  output ssa_pkg::ssa_op_e            issueOp,
  output logic                        issueWide,
  output logic [7:0]                  issueImm,
  output logic [ssa_pkg::VEC_WIDE-1:0] issueDst,
  output logic [ssa_pkg::VEC_WIDE-1:0] issueSrc
);
  import ssa_pkg::*;
  typedef struct packed {
    ssa_op_e      op;
    logic         w;
    logic [7:0]   imm;
    logic [127:0] d;
    logic [127:0] s;
  } ssa_req_s;
  ssa_req_s pend[$];
  ssa_req_s cur;
  logic     slow = 1'b0;
  int       gap = 0;

  initial begin
    issueValid = 1'b0;
    issueOp = OP_HADD_WORD_WRAP;
    issueWide = 1'b0;
    issueImm = 8'h00;
    issueDst = '0;
    issueSrc = '0;
  end

  // Idle cycles scramble operands so stale values never look valid
  always @(posedge clk_sys) begin
    #1;
    if (pend.size() > 0 && gap == 0) begin
      cur = pend.pop_front();
      issueValid = 1'b1;
      issueOp = cur.op;
      issueWide = cur.w;
      issueImm = cur.imm;
      issueDst = cur.d;
      issueSrc = cur.s;
      gap = slow ? 2 : 0;
    end else begin
      issueValid = 1'b0;
      issueDst = ~issueDst;
      issueSrc = ~issueSrc;
      if (gap > 0) gap--;
    end
  end

  task automatic push(ssa_op_e op, logic w, logic [7:0] im,
                      logic [127:0] d, logic [127:0] s);
    pend.push_back({op, w, im, d, s});
  endtask
endmodule

// ---- packed_int_supplemental_simd_alu_tb.sv ----
// Self-checking bench for the packed integer multimedia datapath.
// Assumes the issue model feeds the issue port; bench drives the rest.
`timescale 1ns/1ps
module packed_int_supplemental_simd_alu_tb;
  import ssa_pkg::*;
  logic clk_sys = 1'b0;
  logic reset, groupPresent, task_switched_flag, emulation_control_flag;
  logic issueValid, issueWide, idQuery;
  ssa_op_e issueOp;
  logic [7:0] issueImm;
  logic [127:0] issueDst, issueSrc, result, lastRes, d, s;
  logic [31:0] idLeaf, idEcx;
  logic resultValid, faultInvalidOp, faultDevNa, idValid;
  logic [130:0] expQ[$];
  logic [31:0] idQ[$];
  logic [130:0] e;
  int badCount = 0, checksDone = 0, seed = 32'hc8d6;

  always #20 clk_sys = ~clk_sys;

  ssa_issue_model i_ssa_issue_model (.clk_sys(clk_sys),
    .issueValid(issueValid), .issueOp(issueOp), .issueWide(issueWide),
    .issueImm(issueImm), .issueDst(issueDst), .issueSrc(issueSrc));
  ssa_alu i_ssa_alu (.clk_sys(clk_sys), .reset(reset),
    .groupPresent(groupPresent), .task_switched_flag(task_switched_flag),
    .emulation_control_flag(emulation_control_flag),
    .issueValid(issueValid), .issueOp(issueOp), .issueWide(issueWide),
    .issueImm(issueImm), .issueDst(issueDst), .issueSrc(issueSrc),
    .idQuery(idQuery), .idLeaf(idLeaf), .resultValid(resultValid),
    .result(result), .faultInvalidOp(faultInvalidOp),
    .faultDevNa(faultDevNa), .idValid(idValid), .idEcx(idEcx));

  function automatic int sx(logic [127:0] v, int i, int ew);
    int t;
    t = int'(v >> (i * ew));
    return (t <<< (32 - ew)) >>> (32 - ew);
  endfunction

  function automatic logic [15:0] sat(int v);
    return v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
  endfunction

  // Reference results worked out element by element
  function automatic logic [127:0] refRes(ssa_op_e op, logic w,
      logic [7:0] im, logic [127:0] d, logic [127:0] s);
    logic [127:0] r, o;
    logic [255:0] c;
    int nb, i, k, a, b, n, ew;
    logic sa, isAbs;
    r = '0;
    nb = w ? 16 : 8;
    sa = op inside {OP_HADD_WORD_SATURATE, OP_HSUB_WORD_SATURATE};
    isAbs = op inside {OP_ABS_BYTE, OP_ABS_WORD, OP_ABS_DWORD};
    ew = op inside {OP_ABS_WORD, OP_NEGATE_WORD} ? 16 :
         op inside {OP_ABS_DWORD, OP_NEGATE_DWORD} ? 32 : 8;
    case (op)
      OP_HADD_WORD_WRAP, OP_HADD_WORD_SATURATE, OP_HSUB_WORD_WRAP,
      OP_HSUB_WORD_SATURATE: for (i = 0; i < nb / 2; i++) begin
        o = i < nb / 4 ? d : s;
        k = i % (nb / 4);
        a = sx(o, 2 * k, 16);
        b = sx(o, 2 * k + 1, 16);
        n = op inside {OP_HADD_WORD_WRAP, OP_HADD_WORD_SATURATE} ? a + b : a - b;
        r[16*i+:16] = sa ? sat(n) : n[15:0];
      end
      OP_HADD_DWORD_WRAP, OP_HSUB_DWORD_WRAP: for (i = 0; i < nb / 4; i++) begin
        o = i < nb / 8 ? d : s;
        k = i % (nb / 8);
        a = sx(o, 2 * k, 32);
        b = sx(o, 2 * k + 1, 32);
        n = op == OP_HADD_DWORD_WRAP ? a + b : a - b;
        r[32*i+:32] = n;
      end
      OP_BYTE_MUL_PAIR_ADD_SAT: for (i = 0; i < nb / 2; i++) begin
        n = int'(d[16*i+:8]) * sx(s, 2 * i, 8);
        n = n + int'(d[16*i+8+:8]) * sx(s, 2 * i + 1, 8);
        r[16*i+:16] = sat(n);
      end
      OP_MUL_HIGH_ROUND_SCALE: for (i = 0; i < nb / 2; i++) begin
        n = sx(d, i, 16) * sx(s, i, 16);
        n = ((n >>> 14) + 1) >>> 1;
        r[16*i+:16] = n[15:0];
      end
      OP_BYTE_SHUFFLE: for (i = 0; i < nb; i++) begin
        k = w ? int'(s[8*i+:4]) : int'(s[8*i+:3]);
        r[8*i+:8] = s[8*i+7] ? 8'h00 : d[8*k+:8];
      end
      OP_BYTE_ALIGN_RIGHT: begin
        c = w ? {d, s} : {128'h0, d[63:0], s[63:0]};
        c = c >> (8 * int'(im));
        r = w ? c[127:0] : {64'h0, c[63:0]};
      end
      default: for (i = 0; i < nb * 8 / ew; i++) begin
        a = sx(d, i, ew);
        b = sx(s, i, ew);
        n = isAbs ? (b < 0 ? -b : b) : (b < 0 ? -a : a);
        r = r | ((128'(n) & ((128'h1 << ew) - 1)) << (i * ew));
      end
    endcase
    return r;
  endfunction

  task automatic cmp(string what, logic [127:0] exp, logic [127:0] got);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Outcome is fixed by the flags at push time, so flags stay put until drained
  task automatic issue(ssa_op_e op, logic w, logic [7:0] im,
                       logic [127:0] d, logic [127:0] s);
    logic [2:0] k;
    k = (!groupPresent || emulation_control_flag) ? 3'b010 :
        task_switched_flag ? 3'b100 : 3'b001;
    if (k == 3'b001) lastRes = refRes(op, w, im, d, s);
    expQ.push_back({k, lastRes});
    i_ssa_issue_model.push(op, w, im, d, s);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((expQ.size() || idQ.size() || i_ssa_issue_model.pend.size())
           && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    #1;
    if (n == 500) cmp("drain", 128'h0, 128'h1);
  endtask

  // Watcher: each answer pulse takes the oldest note
  always @(posedge clk_sys) begin
    #2;
    if (!reset && (resultValid || faultInvalidOp || faultDevNa)) begin
      e = expQ.size() ? expQ.pop_front() : '1;
      cmp("outcome", e[130:128], {faultDevNa, faultInvalidOp, resultValid});
      cmp("result", e[127:0], result);
    end
    if (!reset && idValid) begin
      cmp("ident", idQ.size() ? idQ.pop_front() : '1, idEcx);
    end
  end

  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #800000;
    badCount++;
    testDone();
  end

  initial begin
    reset = 1'b1;
    groupPresent = 1'b1;
    task_switched_flag = 1'b0;
    emulation_control_flag = 1'b0;
    idQuery = 1'b0;
    idLeaf = 32'h0;
    lastRes = '0;
    repeat (12) @(posedge clk_sys);
    #1 reset = 1'b0;
    @(posedge clk_sys);
    #2 cmp("idle", '0, {resultValid, faultInvalidOp, faultDevNa, idValid});
    cmp("reset result", '0, result);
    // Every op, both widths, prompt and slow issue; rep 0 hits saturation
    for (int sl = 0; sl < 2; sl++) begin
      i_ssa_issue_model.slow = sl[0];
      for (int w = 0; w < 2; w++) begin
        for (int op = 0; op < 16; op++) begin
          for (int rep = 0; rep < 3; rep++) begin
            d = {$random(seed), $random(seed), $random(seed), $random(seed)};
            s = {$random(seed), $random(seed), $random(seed), $random(seed)};
            if (rep == 0) d = {4{32'h80007FFF}};
            if (rep == 0) s = {8{16'h8000}};
            // Zero source elements left out of conditional negate
            if (op inside {[12:14]}) s = s | {16{8'h01}};
            issue(ssa_op_e'(op), w[0], 8'($unsigned($random(seed)) % 40),
                  d, s);
          end
        end
      end
      drain();
    end
    $display("arithmetic test done");
    // All flag combinations; faults must leave the result alone
    for (int f = 0; f < 8; f++) begin
      {groupPresent, emulation_control_flag, task_switched_flag} = 3'(f ^ 4);
      issue(OP_ABS_BYTE, 1'b1, 8'h00, {4{$random(seed)}},
            {4{$random(seed)}});
      drain();
    end
    $display("fault test done");
    // Back-to-back identification queries, feature leaf and others
    for (int f = 0; f < 4; f++) begin
      groupPresent = f[0];
      idLeaf = f[1] ? 32'h1 : ($random(seed) | 32'h2);
      idQuery = 1'b1;
      idQ.push_back(ECX_RESET | (32'(f[1] & f[0]) << CAP_BIT));
      @(posedge clk_sys);
      #1;
    end
    idQuery = 1'b0;
    drain();
    $display("identification test done");
    testDone();
  end
endmodule
